// ==== rtl/bda_cfg.svh ====
// Purpose: Constants for the decimal-adjust / decrement datapath
// Assumes: 16-bit instruction words, 8-bit data
// Notes:   Included by bare name; definitions only
`ifndef BDA_CFG_SVH
`define BDA_CFG_SVH

// Operand-free decimal adjust word
`define BDA_ADJ_WORD 16'h0007
// Decrement opcode field, bits 15:10
`define BDA_DEC_OPC 6'h01
`define BDA_OPC_HI 15
`define BDA_OPC_LO 10
// Field positions inside the decrement word
`define BDA_DEST_BIT 9
`define BDA_BANK_BIT 8
// BCD correction constants
`define BDA_BCD_MAX 4'h9
`define BDA_BCD_FIX 4'h6
// Access bank split: low part maps to bank 0, high part to bank F
`define BDA_ACC_SPLIT 8'h80
`define BDA_ACC_HI_BANK 4'hF
// Reset values
`define BDA_W_RST 8'h00
`define BDA_BANK_RST 4'h0

`endif

// ==== rtl/bda_pkg.sv ====
// Purpose: Types for the decimal-adjust / decrement datapath
// Assumes: Constants come from bda_cfg.svh
// Notes:   Types only
`default_nettype none
package bda_pkg;
   // Status flags kept by the datapath
   typedef struct packed
   {
      logic negative;
      logic overflow_flag;
      logic zero;
      logic digit_carry_flag;
      logic carry;
   } bda_flags_t;

   // File register write request
   typedef struct packed
   {
      logic we;
      logic [11:0] addr;
      logic [7:0] data;
   } bda_fwrite_t;

   // Decoded operation
   typedef enum logic [1:0]
   {
      BDA_OP_NONE,
      BDA_OP_ADJ,
      BDA_OP_DEC
   } bda_op_t;
endpackage : bda_pkg
`default_nettype wire

// ==== rtl/bda_decoder.sv ====
// Purpose: Classifies an instruction word for the datapath
// Assumes: Word valid in the cycle it is presented
// Notes:   Pure combinational
`default_nettype none
`include "bda_cfg.svh"
module bda_decoder
   import bda_pkg::*;
(
   input wire logic [15:0] instr,
   output logic [11:0] fa_addr,
   output bda_op_t op,
   output logic dest_file
);
   // Access bank: low offsets map to bank 0, high offsets to the top bank
   logic [3:0] acc_bank;
   assign acc_bank = (instr[7:0] < `BDA_ACC_SPLIT) ? 4'h0 : `BDA_ACC_HI_BANK;

   // Opcode classification
   always_comb
   begin
      op = BDA_OP_NONE;
      if (instr == `BDA_ADJ_WORD)
         op = BDA_OP_ADJ;
      else if (instr[`BDA_OPC_HI:`BDA_OPC_LO] == `BDA_DEC_OPC)
         op = BDA_OP_DEC;
   end

   assign dest_file = instr[`BDA_DEST_BIT];
   assign fa_addr = {acc_bank, instr[7:0]};
endmodule : bda_decoder
`default_nettype wire

// ==== rtl/bda_alu.sv ====
// Purpose: Execution datapath for decimal adjust and file decrement
// Assumes: File read data arrives combinationally for FILE_ADDR
// Notes:   One instruction per clock when INSTR_VALID is high
`default_nettype none
`include "bda_cfg.svh"
module bda_alu
   import bda_pkg::*;
#(
   parameter int DW = 8
)
(
   input wire logic MCLK,
   input wire logic RESET,
   input wire logic INSTR_VALID,
   input wire logic [15:0] INSTR,
   input wire logic [3:0] BANK_SELECT_REGISTER,
   input wire logic [DW-1:0] FILE_RDATA,
   output logic [11:0] FILE_ADDR,
   output bda_fwrite_t FILE_WR,
   output logic [DW-1:0] W_OUT,
   output bda_flags_t FLAGS,
   output logic DONE
);

   ////////////////////////////////////////////////////////////////////////
   // Decode and address formation
   bda_op_t op;
   logic dest_file;
   logic [11:0] raw_addr;

   bda_decoder u_dec
   (
      .instr(INSTR),
      .fa_addr(raw_addr),
      .op(op),
      .dest_file(dest_file)
   );

   // Bank bit picks bank select or the decoder's access-bank address
   function automatic logic [11:0] form_addr(input logic bank_bit, input logic [11:0] acc_addr,
      input logic [3:0] bank_sel);
      if (bank_bit)
         form_addr = {bank_sel, acc_addr[7:0]};
      else
         form_addr = acc_addr;
   endfunction : form_addr

   assign FILE_ADDR = form_addr(INSTR[`BDA_BANK_BIT], raw_addr, BANK_SELECT_REGISTER);

   ////////////////////////////////////////////////////////////////////////
   // Arithmetic
   logic [DW-1:0] w_r, w_nxt;
   bda_flags_t fl_r, fl_nxt;
   bda_fwrite_t wr_r, wr_nxt;
   logic done_r, done_nxt;
   logic [4:0] lo_sum;
   logic [4:0] hi_sum;
   logic [3:0] lo_in;
   logic [3:0] hi_in;
   logic lo_fix;
   logic hi_fix;
   logic [DW:0] dec_full;
   logic [4:0] dec_lo;

   // Adjust: nibble corrections, carry ripples from low into high nibble
   always_comb
   begin
      lo_in = w_r[3:0];
      lo_fix = (lo_in > `BDA_BCD_MAX) || fl_r.digit_carry_flag;
      lo_sum = lo_fix ? ({1'b0, lo_in} + {1'b0, `BDA_BCD_FIX}) : {1'b0, lo_in};
      hi_in = w_r[7:4] + {3'b000, lo_sum[4]};
      hi_fix = (w_r[7:4] > `BDA_BCD_MAX) || fl_r.carry || (lo_sum[4] && hi_in > `BDA_BCD_MAX);
      hi_sum = hi_fix ? ({1'b0, hi_in} + {1'b0, `BDA_BCD_FIX}) : {1'b0, hi_in};
   end

   // Decrement as add of all-ones so carry means no borrow
   assign dec_full = {1'b0, FILE_RDATA} + {1'b0, {DW{1'b1}}};
   assign dec_lo = {1'b0, FILE_RDATA[3:0]} + 5'h0F;

   ////////////////////////////////////////////////////////////////////////
   // Next-state: one instruction completes per clock
   always_comb
   begin
      w_nxt = w_r;
      fl_nxt = fl_r;
      wr_nxt = '0;
      done_nxt = 1'b0;
      if (INSTR_VALID)
      begin
         unique case (op)
            BDA_OP_ADJ:
            begin
               w_nxt = {hi_sum[3:0], lo_sum[3:0]};
               // Carry is sticky: a set carry stays set through the adjust
               fl_nxt.carry = fl_r.carry | hi_sum[4] | hi_fix;
               done_nxt = 1'b1;
            end
            BDA_OP_DEC:
            begin
               if (dest_file)
               begin
                  wr_nxt.we = 1'b1;
                  wr_nxt.addr = FILE_ADDR;
                  wr_nxt.data = dec_full[DW-1:0];
               end
               else
                  w_nxt = dec_full[DW-1:0];
               // Carry and digit carry report no borrow
               fl_nxt.carry = dec_full[DW];
               fl_nxt.digit_carry_flag = dec_lo[4];
               fl_nxt.negative = dec_full[DW-1];
               fl_nxt.zero = (dec_full[DW-1:0] == '0);
               // Only 0x80 minus one overflows signed range
               fl_nxt.overflow_flag = FILE_RDATA[DW-1] & ~dec_full[DW-1];
               done_nxt = 1'b1;
            end
            BDA_OP_NONE:
            begin
               done_nxt = 1'b0;
            end
         endcase
      end
   end

   // State registers
   always_ff @(posedge MCLK)
   begin
      if (RESET)
      begin
         w_r <= `BDA_W_RST;
         fl_r <= '0;
         wr_r <= '0;
         done_r <= 1'b0;
      end
      else
      begin
         w_r <= w_nxt;
         fl_r <= fl_nxt;
         wr_r <= wr_nxt;
         done_r <= done_nxt;
      end
   end

   assign W_OUT = w_r;
   assign FLAGS = fl_r;
   assign FILE_WR = wr_r;
   assign DONE = done_r;

   ////////////////////////////////////////////////////////////////////////
   // Checks: inputs are sampled before the edge, registered results one edge later, FILE_ADDR in the same cycle
   sequence s_dec_w;
      INSTR_VALID && op == BDA_OP_DEC && !dest_file;
   endsequence

   // Nothing executed: pulses low, accumulator and flags left alone
   sequence s_no_effect;
      !DONE && !FILE_WR.we && $stable(W_OUT) && $stable(FLAGS);
   endsequence

   // Decode and refusal
   a_adj_decode: assert property (@(posedge MCLK) disable iff (RESET)
      (INSTR_VALID && INSTR == `BDA_ADJ_WORD) |=> DONE && !FILE_WR.we)
      else $error("decimal adjust not executed");
   a_refused_word: assert property (@(posedge MCLK) disable iff (RESET)
      (!INSTR_VALID || op == BDA_OP_NONE) |=> s_no_effect)
      else $error("idle or unknown word had an effect");

   // Adjust results
   a_adj_low_fix: assert property (@(posedge MCLK) disable iff (RESET)
      (INSTR_VALID && op == BDA_OP_ADJ && w_r[3:0] > 4'h9 && w_r[7:4] < 4'h9 && !fl_r.carry)
      |=> W_OUT[3:0] == 4'($past(w_r[3:0]) + 4'h6))
      else $error("low nibble not corrected");
   a_adj_high_fix: assert property (@(posedge MCLK) disable iff (RESET)
      (INSTR_VALID && op == BDA_OP_ADJ && w_r[3:0] < 4'hA && !fl_r.digit_carry_flag
       && fl_r.carry) |=> W_OUT[7:4] == 4'($past(w_r[7:4]) + 4'h6))
      else $error("high nibble not corrected");
   a_adj_bcd_out: assert property (@(posedge MCLK) disable iff (RESET)
      (INSTR_VALID && op == BDA_OP_ADJ && !fl_r.digit_carry_flag && !fl_r.carry)
      |=> W_OUT[3:0] < 4'hA && W_OUT[7:4] < 4'hA)
      else $error("result not packed BCD");

   // Decrement results and addressing, then flags left alone by adjust
   a_dec_to_w: assert property (@(posedge MCLK) disable iff (RESET)
      s_dec_w |=> W_OUT == 8'($past(FILE_RDATA) - 8'h01) && !FILE_WR.we)
      else $error("decrement to accumulator wrong");
   a_dec_to_file: assert property (@(posedge MCLK) disable iff (RESET)
      (INSTR_VALID && op == BDA_OP_DEC && dest_file)
      |=> FILE_WR.we && FILE_WR.data == 8'($past(FILE_RDATA) - 8'h01) && $stable(W_OUT))
      else $error("decrement write-back wrong");
   a_wr_addr: assert property (@(posedge MCLK) disable iff (RESET)
      (INSTR_VALID && op == BDA_OP_DEC && dest_file) |=> FILE_WR.addr == $past(FILE_ADDR))
      else $error("write-back address wrong");
   a_access_bank: assert property (@(posedge MCLK) disable iff (RESET)
      (!INSTR[8] && INSTR[7:0] < 8'h80) |-> FILE_ADDR == {4'h0, INSTR[7:0]})
      else $error("access bank not used");
   a_access_high: assert property (@(posedge MCLK) disable iff (RESET)
      (!INSTR[8] && INSTR[7:0] >= 8'h80) |-> FILE_ADDR == {4'hF, INSTR[7:0]})
      else $error("access bank high half misplaced");
   a_bank_select: assert property (@(posedge MCLK) disable iff (RESET)
      INSTR[8] |-> FILE_ADDR == {BANK_SELECT_REGISTER, INSTR[7:0]})
      else $error("bank select not used");
   a_dec_zero: assert property (@(posedge MCLK) disable iff (RESET)
      (INSTR_VALID && op == BDA_OP_DEC && FILE_RDATA == 8'h01)
      |=> FLAGS.zero && FLAGS.carry && DONE)
      else $error("decrement flags wrong");
   a_dec_overflow: assert property (@(posedge MCLK) disable iff (RESET)
      (INSTR_VALID && op == BDA_OP_DEC && FILE_RDATA == 8'h80)
      |=> FLAGS.overflow_flag && !FLAGS.negative && FLAGS.carry)
      else $error("decrement overflow flag wrong");
   a_dec_borrow: assert property (@(posedge MCLK) disable iff (RESET)
      (INSTR_VALID && op == BDA_OP_DEC && FILE_RDATA == 8'h00)
      |=> FLAGS.negative && !FLAGS.carry && !FLAGS.digit_carry_flag && !FLAGS.zero)
      else $error("decrement borrow flags wrong");
   a_adj_flags_kept: assert property (@(posedge MCLK) disable iff (RESET)
      (INSTR_VALID && op == BDA_OP_ADJ) |=> $stable(FLAGS.zero) && $stable(FLAGS.negative)
      && $stable(FLAGS.overflow_flag) && $stable(FLAGS.digit_carry_flag))
      else $error("adjust touched extra flags");
endmodule : bda_alu
`default_nettype wire

// ==== verif/bda_alu_test.sv ====
// Purpose: Self-checking bench for the decimal-adjust / decrement datapath
// Assumes: One instruction per cycle; registered outputs land one edge after the word, FILE_ADDR at once
// Notes:   Rows run back to back; reset and the idle-state adjust come after
`default_nettype none
module bda_alu_test
   import bda_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // Stimulus row: valid, word, bank select, file contents
   typedef struct packed
   {
      logic v;
      logic [15:0] i;
      logic [3:0] b;
      logic [7:0] d;
   } bda_row_t;

   logic MCLK = 1'b0;
   logic RESET = 1'b1;
   logic INSTR_VALID = 1'b0;
   logic [15:0] INSTR = 16'h0000;
   logic [3:0] BANK_SELECT_REGISTER = 4'h0;
   logic [7:0] FILE_RDATA = 8'h00;
   logic [11:0] FILE_ADDR;
   bda_fwrite_t FILE_WR;
   logic [7:0] W_OUT;
   bda_flags_t FLAGS;
   logic DONE;
   int n_mismatch = 0;
   int n_compared = 0;
   logic e_done = 1'b0;
   logic e_we = 1'b0;
   bda_fwrite_t e_wr = '0;
   logic [7:0] e_w = 8'h00;
   bda_flags_t e_f = '0;
   // Chained so each adjust sees the accumulator and flags left by the row before
   bda_row_t rows [20] = '{
      '{1'b1, 16'h0705, 4'h2, 8'h01}, '{1'b1, 16'h0580, 4'h7, 8'h80},
      '{1'b1, 16'h0007, 4'h0, 8'h00}, '{1'b1, 16'h0410, 4'h3, 8'h00},
      '{1'b1, 16'h0007, 4'h0, 8'h00}, '{1'b1, 16'h04F0, 4'h3, 8'hA6},
      '{1'b1, 16'h0007, 4'h0, 8'h00}, '{1'b1, 16'h0520, 4'h0, 8'h13},
      '{1'b1, 16'h0007, 4'h0, 8'h00}, '{1'b0, 16'h0007, 4'h0, 8'h00},
      '{1'b1, 16'h0807, 4'h0, 8'h00}, '{1'b1, 16'h0600, 4'h5, 8'h00},
      '{1'b1, 16'h0007, 4'h0, 8'h00}, '{1'b1, 16'h0480, 4'h9, 8'h0B},
      '{1'b1, 16'h077F, 4'h4, 8'h00}, '{1'b1, 16'h0007, 4'h0, 8'h00},
      '{1'b1, 16'h0580, 4'h1, 8'hA6}, '{1'b1, 16'h0600, 4'h0, 8'h00},
      '{1'b1, 16'h0007, 4'h0, 8'h00}, '{1'b1, 16'h0007, 4'h0, 8'h00}};

   bda_alu u_dut
   (
      .MCLK(MCLK),
      .RESET(RESET),
      .INSTR_VALID(INSTR_VALID),
      .INSTR(INSTR),
      .BANK_SELECT_REGISTER(BANK_SELECT_REGISTER),
      .FILE_RDATA(FILE_RDATA),
      .FILE_ADDR(FILE_ADDR),
      .FILE_WR(FILE_WR),
      .W_OUT(W_OUT),
      .FLAGS(FLAGS),
      .DONE(DONE)
   );

   ////////////////////////////////////////////////////////////////////////
   // Clock, 8 ns period
   always #4 MCLK = ~MCLK;

   // Compare of multi-bit results
   task automatic chk_val(input logic [20:0] got, input logic [20:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_val

   // Compare of single-bit pulses
   task automatic chk_bit(input logic got, input logic exp);
      chk_val({20'h00000, got}, {20'h00000, exp});
   endtask : chk_bit

   // Closing point for both the main sequence and the watchdog
   task automatic give_verdict();
      if (n_mismatch == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : give_verdict

   ////////////////////////////////////////////////////////////////////////
   // Present one word, check the previous word's results, then predict
   task automatic step(input bda_row_t r);
      logic [11:0] a;
      logic [7:0] q;
      logic [8:0] s;
      @(posedge MCLK);
      INSTR_VALID <= r.v;
      INSTR <= r.i;
      BANK_SELECT_REGISTER <= r.b;
      FILE_RDATA <= r.d;
      #1;
      chk_bit(DONE, e_done);
      chk_val({13'h0000, W_OUT}, {13'h0000, e_w});
      chk_val({16'h0000, FLAGS}, {16'h0000, e_f});
      if (e_we)
         chk_val(FILE_WR, e_wr);
      else
         chk_bit(FILE_WR.we, 1'b0);
      // Access bank: low half bank 0, high half bank F
      a = r.i[8] ? {r.b, r.i[7:0]} : {(r.i[7] ? 4'hF : 4'h0), r.i[7:0]};
      e_done = 1'b0;
      e_we = 1'b0;
      if (r.v && r.i == 16'h0007)
      begin
         s = {1'b0, e_w};
         if (s[3:0] > 4'h9 || e_f.digit_carry_flag)
            s = s + 9'h006;
         // High digit corrects on its own value, on the carry flag, or when the low digit's carry lifts it past 9
         if (s[7:4] > 4'h9 || e_w[7:4] > 4'h9 || e_f.carry)
            s = s + 9'h060;
         e_w = s[7:0];
         e_f.carry = e_f.carry | s[8];
         e_done = 1'b1;
      end
      else if (r.v && r.i[15:10] == 6'h01)
      begin
         chk_val({9'h000, FILE_ADDR}, {9'h000, a});
         q = r.d - 8'h01;
         e_f = {q[7], r.d == 8'h80, q == 8'h00, r.d[3:0] != 4'h0, r.d != 8'h00};
         e_done = 1'b1;
         e_we = r.i[9];
         e_wr = {1'b1, a, q};
         if (!r.i[9])
            e_w = q;
      end
   endtask : step

   ////////////////////////////////////////////////////////////////////////
   // Watchdog: the whole run needs well under 100 cycles
   initial
   begin
      repeat (2000) @(posedge MCLK);
      n_mismatch++;
      give_verdict();
   end

   // Main sequence
   initial
   begin
      repeat (8) @(posedge MCLK);
      RESET <= 1'b0;
      foreach (rows[k])
         step(rows[k]);
      step('0);
      // Reset in mid-run clears accumulator, flags and pulses
      @(posedge MCLK);
      RESET <= 1'b1;
      repeat (2) @(posedge MCLK);
      #1;
      chk_val({13'h0000, W_OUT}, 21'h000000);
      chk_val({16'h0000, FLAGS}, 21'h000000);
      chk_val(FILE_WR, 21'h000000);
      chk_bit(DONE, 1'b0);
      @(posedge MCLK);
      RESET <= 1'b0;
      e_w = 8'h00;
      e_f = '0;
      e_done = 1'b0;
      e_we = 1'b0;
      // Adjust at the second edge out of reset: digits in range, no flags, no change
      step('{1'b1, 16'h0007, 4'h0, 8'h00});
      step('0);
      give_verdict();
   end
endmodule : bda_alu_test
`default_nettype wire
